// file: include/l2seq_defs.svh
`ifndef L2SEQ_DEFS_SVH
`define L2SEQ_DEFS_SVH
// tag word layout
`define L2SEQ_TAG_W      26
`define L2SEQ_PTAG_MSB   25
`define L2SEQ_PTAG_LSB   4
`define L2SEQ_PRIMARY_INDEX_FIELD_MSB   3
`define L2SEQ_PRIMARY_INDEX_FIELD_LSB   2
`define L2SEQ_ST_MSB     1
`define L2SEQ_ST_LSB     0
`define L2SEQ_PA_TAG_MSB 39
`define L2SEQ_PA_TAG_LSB 18
`define L2SEQ_VA_IDX_MSB 13
`define L2SEQ_VA_IDX_LSB 12
// register byte offsets
`define L2SEQ_REG_TAG_LO 8'h00
`define L2SEQ_REG_TAG_HI 8'h04
`define L2SEQ_REG_CHECK  8'h08
`define L2SEQ_REG_STATUS 8'h0C
`define L2SEQ_REG_CONFIG 8'h10
`define L2SEQ_RST_WORD   32'h0000_0000
`define L2SEQ_RST_CHECK  10'h000
`define L2SEQ_RESP_OKAY  2'b00
`define L2SEQ_RESP_SLV   2'b10
// way prediction table entries
`define L2SEQ_WPT_DEPTH  8192
`endif

// file: include/l2seq_pkg.sv
package l2seq_pkg;
  typedef enum logic [1:0] {
    L2SEQ_ST_INVALID = 2'b00,
    L2SEQ_ST_SHARED  = 2'b01,
    L2SEQ_ST_CLEAN   = 2'b10,
    L2SEQ_ST_DIRTY   = 2'b11
  } l2seq_blk_e;

  typedef enum logic [1:0] {
    L2SEQ_IDLE = 2'b00,
    L2SEQ_RUN  = 2'b01
  } l2seq_fsm_e;

  typedef enum logic [3:0] {
    L2SEQ_K_RD4    = 4'h0, // diagnostic data load
    L2SEQ_K_RD8    = 4'h1, // data cache refill
    L2SEQ_K_RD16I  = 4'h2, // instruction cache refill
    L2SEQ_K_RDWB   = 4'h3, // dirty block fetch for write-back
    L2SEQ_K_TAGRD  = 4'h4, // diagnostic tag load
    L2SEQ_K_COHRD  = 4'h5, // coherency tag lookup
    L2SEQ_K_WR4    = 4'h6, // diagnostic data store
    L2SEQ_K_WR8    = 4'h7, // primary dirty block write-back
    L2SEQ_K_WRFILL = 4'h8, // refill from system side
    L2SEQ_K_TAGWR  = 4'h9  // state change, coherency, diag tag store
  } l2seq_kind_e;

  typedef struct packed {
    l2seq_kind_e kind;
    logic [39:0] pa;
    logic [13:0] va;
    logic        way;
    l2seq_blk_e  state;
  } l2seq_req_s;

  typedef struct packed {
    logic         en;
    logic         data_en;
    logic         data_we;
    logic         tag_oe;
    logic [17:0]  index;
    logic [2:0]   qw;
    logic         data_way_select;
    logic         tag_way_select;
    logic         tag_index_low_bit;
    logic [25:0]  l2_tag_bus;
    logic [127:0] data;
    logic [9:0]   check;
  } l2seq_sram_s;
endpackage : l2seq_pkg

// file: hw/l2seq_ctrl.sv
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`include "l2seq_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module l2seq_ctrl #(
  parameter int WPT_DEPTH = `L2SEQ_WPT_DEPTH
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_ce,
  input  wire logic                  i_l2_sequencing_clock,
  input  wire logic                  i_block_size_setting,
  input  wire logic [2:0]            i_cache_capacity_setting,
  input  wire logic [1:0]            i_cache_clock_phase_tap,
  input  wire logic                  i_req_valid,
  input  wire l2seq_pkg::l2seq_req_s i_req,
  output logic                       o_req_ready,
  input  wire logic [127:0]          i_wr_data,
  output logic                       o_wr_take,
  output l2seq_pkg::l2seq_sram_s     o_sram,
  input  wire logic [127:0]          i_sram_data,
  input  wire logic [9:0]            i_sram_check,
  input  wire logic [25:0]           i_l2_tag_bus,
  output logic                       o_rd_valid,
  output logic [127:0]               o_rd_data,
  output logic                       o_done,
  output logic                       o_hit,
  output logic                       o_hit_way,
  output logic                       o_miss,
  output logic                       o_purge,
  output logic                       o_coh_found,
  output logic [1:0]                 o_primary_index_field,
  input  wire logic [7:0]            i_awaddr,
  input  wire logic                  i_awvalid,
  output logic                       o_awready,
  input  wire logic [31:0]           i_wdata,
  input  wire logic [3:0]            i_wstrb,
  input  wire logic                  i_wvalid,
  output logic                       o_wready,
  output logic [1:0]                 o_bresp,
  output logic                       o_bvalid,
  input  wire logic                  i_bready,
  input  wire logic [7:0]            i_araddr,
  input  wire logic                  i_arvalid,
  output logic                       o_arready,
  output logic [31:0]                o_rdata,
  output logic [1:0]                 o_rresp,
  output logic                       o_rvalid,
  input  wire logic                  i_rready
);
  import l2seq_pkg::*;

  typedef struct packed {
    logic [2:0]   sync;
    logic         lvl;
    logic [2:0]   tsh;
    logic         cfg_done;
    logic         blk32;
    logic [2:0]   cap;
    logic [1:0]   tap;
    l2seq_fsm_e   fsm;
    l2seq_req_s   req;
    logic [3:0]   cnt;
    logic         pway;
    logic         reissued;
    logic [25:0]  tag_p;
    logic [25:0]  tag_o;
    logic [31:0]  tag_lo;
    logic [31:0]  tag_hi;
    logic [9:0]   ecc;
    l2seq_sram_s  sram;
    logic         rd_valid;
    logic [127:0] rd_data;
    logic         done;
    logic         hit;
    logic         hit_way;
    logic         miss;
    logic         purge;
    logic         coh_found;
    logic [1:0]   primary_index_field;
    logic         wr_take;
    logic         aw_ok;
    logic         w_ok;
    logic [7:0]   awaddr;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
  } l2seq_state_s;

  l2seq_state_s s_q;
  l2seq_state_s s_d;
  logic         wpt_mem [WPT_DEPTH];
  logic         wpt_we;
  logic [12:0]  wpt_widx;
  logic         wpt_wval;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] l2seq_chk_gen(input logic [127:0] d);
    logic [9:0] c;
    c = '0;
    for (int i = 0; i < 128; i++) begin
      c[i % 10] = c[i % 10] ^ d[i];
    end
    return c;
  endfunction : l2seq_chk_gen

  // prediction index: small caches pad the top with zeros
  function automatic logic [12:0] l2seq_wpt_idx(input logic [39:0] pa, input logic b32,
                                                input logic [2:0] cap);
    logic [12:0] x;
    x = b32 ? pa[19:7] : pa[18:6];
    if (cap == 3'h0) begin
      x = b32 ? {2'b00, pa[17:7]} : {1'b0, pa[17:6]};
    end else if (cap == 3'h1 && b32) begin
      x = {1'b0, pa[18:7]};
    end
    return x;
  endfunction : l2seq_wpt_idx

  function automatic logic [3:0] l2seq_nqw(input l2seq_kind_e k, input logic b32);
    logic [3:0] n;
    case (k)
      L2SEQ_K_RD8, L2SEQ_K_WR8:       n = 4'h2;
      L2SEQ_K_RD16I:                  n = 4'h4;
      L2SEQ_K_RDWB, L2SEQ_K_WRFILL:   n = b32 ? 4'h8 : 4'h4;
      default:                        n = 4'h1;
    endcase
    return n;
  endfunction : l2seq_nqw

  function automatic logic l2seq_match(input logic [25:0] t, input logic [39:0] pa);
    return t[`L2SEQ_PTAG_MSB:`L2SEQ_PTAG_LSB] == pa[`L2SEQ_PA_TAG_MSB:`L2SEQ_PA_TAG_LSB]
           && t[`L2SEQ_ST_MSB:`L2SEQ_ST_LSB] != L2SEQ_ST_INVALID;
  endfunction : l2seq_match

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        tick;
    logic        step;
    logic [3:0]  n;
    logic        is_wr;
    logic        tag_only;
    logic        pred;
    logic        last;
    logic [25:0] tp;
    logic [25:0] to;
    logic        diag;
    logic        wdo;
    logic [3:0]  tv;
    s_d         = s_q;
    wpt_we      = 1'b0;
    wpt_widx    = l2seq_wpt_idx(s_q.req.pa, s_q.blk32, s_q.cap);
    wpt_wval    = 1'b0;
    s_d.rd_valid  = 1'b0;
    s_d.done      = 1'b0;
    s_d.purge     = 1'b0;
    s_d.coh_found = 1'b0;
    s_d.wr_take   = 1'b0;

    // link clock: a rise counts once second and third stage agree
    s_d.sync = {s_q.sync[1:0], i_l2_sequencing_clock};
    tick     = (s_q.sync[1] == s_q.sync[2]) && s_q.sync[2] && !s_q.lvl;
    if (s_q.sync[1] == s_q.sync[2]) begin
      s_d.lvl = s_q.sync[2];
    end
    s_d.tsh = {s_q.tsh[1:0], tick};
    tv      = {s_q.tsh, tick};
    step    = tv[s_q.tap];

    // straps caught once, first cycle after reset release
    if (!s_q.cfg_done) begin
      s_d.cfg_done = 1'b1;
      s_d.blk32    = i_block_size_setting;
      s_d.cap      = i_cache_capacity_setting;
      s_d.tap      = i_cache_clock_phase_tap;
    end

    n        = l2seq_nqw(s_q.req.kind, s_q.blk32);
    is_wr    = s_q.req.kind inside {L2SEQ_K_WR4, L2SEQ_K_WR8, L2SEQ_K_WRFILL, L2SEQ_K_TAGWR};
    tag_only = s_q.req.kind inside {L2SEQ_K_TAGRD, L2SEQ_K_COHRD, L2SEQ_K_TAGWR};
    pred     = s_q.req.kind inside {L2SEQ_K_RD8, L2SEQ_K_RD16I};
    diag     = s_q.req.kind inside {L2SEQ_K_RD4, L2SEQ_K_WR4, L2SEQ_K_TAGRD};
    wdo      = s_q.req.kind inside {L2SEQ_K_WR8, L2SEQ_K_WRFILL};
    last     = is_wr ? (s_q.cnt == n - 4'h1) : (s_q.cnt == n);
    tp       = (s_q.cnt == 4'h1) ? i_l2_tag_bus : s_q.tag_p;
    to       = (s_q.cnt == 4'h2) ? i_l2_tag_bus : s_q.tag_o;

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    if (o_awready && i_awvalid) begin
      s_d.aw_ok  = 1'b1;
      s_d.awaddr = i_awaddr;
    end
    if (o_wready && i_wvalid) begin
      s_d.w_ok  = 1'b1;
      s_d.wdata = i_wdata;
      s_d.wstrb = i_wstrb;
    end
    if (s_q.aw_ok && s_q.w_ok) begin
      s_d.aw_ok  = 1'b0;
      s_d.w_ok   = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = `L2SEQ_RESP_OKAY;
      for (int b = 0; b < 4; b++) begin
        if (s_q.wstrb[b]) begin
          case (s_q.awaddr)
            `L2SEQ_REG_TAG_LO: s_d.tag_lo[b*8 +: 8] = s_q.wdata[b*8 +: 8];
            `L2SEQ_REG_TAG_HI: s_d.tag_hi[b*8 +: 8] = s_q.wdata[b*8 +: 8];
            default: ;
          endcase
        end
      end
      if (s_q.awaddr == `L2SEQ_REG_CHECK) begin
        if (s_q.wstrb[0]) s_d.ecc[7:0] = s_q.wdata[7:0];
        if (s_q.wstrb[1]) s_d.ecc[9:8] = s_q.wdata[9:8];
      end
      if (!(s_q.awaddr inside {`L2SEQ_REG_TAG_LO, `L2SEQ_REG_TAG_HI, `L2SEQ_REG_CHECK,
                                `L2SEQ_REG_STATUS, `L2SEQ_REG_CONFIG})) begin
        s_d.bresp = `L2SEQ_RESP_SLV;
      end
    end else if (s_q.bvalid && i_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (o_arready && i_arvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = `L2SEQ_RESP_OKAY;
      case (i_araddr)
        `L2SEQ_REG_TAG_LO: s_d.rdata = s_q.tag_lo;
        `L2SEQ_REG_TAG_HI: s_d.rdata = s_q.tag_hi;
        `L2SEQ_REG_CHECK:  s_d.rdata = {22'h000000, s_q.ecc};
        `L2SEQ_REG_STATUS: s_d.rdata = {27'h0000000, s_q.reissued, s_q.miss, s_q.hit_way,
                                        s_q.hit, s_q.fsm == L2SEQ_RUN};
        `L2SEQ_REG_CONFIG: s_d.rdata = {26'h0000000, s_q.tap, s_q.cap, s_q.blk32};
        default: begin
          s_d.rdata = `L2SEQ_RST_WORD;
          s_d.rresp = `L2SEQ_RESP_SLV;
        end
      endcase
    end else if (s_q.rvalid && i_rready) begin
      s_d.rvalid = 1'b0;
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    case (s_q.fsm)
      L2SEQ_IDLE: begin
        // a finished write must not keep its strobes on the arrays
        s_d.sram.en      = 1'b0;
        s_d.sram.data_en = 1'b0;
        s_d.sram.data_we = 1'b0;
        s_d.sram.tag_oe  = 1'b0;
        if (i_req_valid && s_q.cfg_done) begin
          s_d.req      = i_req;
          s_d.fsm      = L2SEQ_RUN;
          s_d.cnt      = 4'h0;
          s_d.reissued = 1'b0;
          s_d.hit      = 1'b0;
          s_d.miss     = 1'b0;
          if (i_req.kind inside {L2SEQ_K_RD8, L2SEQ_K_RD16I}) begin
            s_d.pway = wpt_mem[l2seq_wpt_idx(i_req.pa, s_q.blk32, s_q.cap)];
          end else if (i_req.kind inside {L2SEQ_K_RD4, L2SEQ_K_WR4, L2SEQ_K_TAGRD}) begin
            s_d.pway = i_req.va[0];
          end else begin
            s_d.pway = i_req.way;
          end
        end
      end
      L2SEQ_RUN: begin
        if (step) begin
          // address phase: sram outputs hold until the next step or until idle; o_wr_take is a one-cycle pulse
          s_d.sram.en = s_q.cnt < n;
          if (s_q.cnt < n) begin
            s_d.sram.index             = s_q.req.pa[23:6];
            s_d.sram.qw                = s_q.cnt[2:0];
            s_d.sram.data_way_select   = s_q.pway;
            s_d.sram.tag_way_select    = (pred && s_q.cnt == 4'h1) ? !s_q.pway : s_q.pway;
            s_d.sram.tag_index_low_bit = s_q.blk32 ? 1'b0 : s_q.req.pa[6];
            s_d.sram.data_en           = !tag_only;
            s_d.sram.data_we           = is_wr && !tag_only;
            s_d.sram.tag_oe            = s_q.cnt == 4'h0 &&
                                         s_q.req.kind inside {L2SEQ_K_WRFILL, L2SEQ_K_TAGWR};
            s_d.sram.l2_tag_bus        = {s_q.req.pa[`L2SEQ_PA_TAG_MSB:`L2SEQ_PA_TAG_LSB],
                                          s_q.req.va[`L2SEQ_VA_IDX_MSB:`L2SEQ_VA_IDX_LSB],
                                          s_q.req.state};
            if (s_q.req.kind == L2SEQ_K_WR4) begin
              s_d.sram.data  = s_q.req.va[3] ? {s_q.tag_hi, s_q.tag_lo, 64'h0}
                                             : {64'h0, s_q.tag_hi, s_q.tag_lo};
              s_d.sram.check = s_q.ecc;
            end else begin
              s_d.sram.data  = i_wr_data;
              s_d.sram.check = l2seq_chk_gen(i_wr_data);
            end
            s_d.wr_take = wdo;
          end else begin
            s_d.sram.data_en = 1'b0;
            s_d.sram.data_we = 1'b0;
            s_d.sram.tag_oe  = 1'b0;
          end
          // data phase: one step behind the address
          if (!is_wr && s_q.cnt != 4'h0) begin
            if (s_q.cnt == 4'h1) s_d.tag_p = i_l2_tag_bus;
            if (s_q.cnt == 4'h2) s_d.tag_o = i_l2_tag_bus;
            if (s_q.req.kind == L2SEQ_K_RD4) begin
              {s_d.tag_hi, s_d.tag_lo} = s_q.req.va[3] ? i_sram_data[127:64]
                                                       : i_sram_data[63:0];
              s_d.ecc = i_sram_check;
            end else if (!tag_only) begin
              s_d.rd_valid = 1'b1;
              s_d.rd_data  = i_sram_data;
            end
          end
          s_d.cnt = s_q.cnt + 4'h1;
          if (last) begin
            s_d.fsm  = L2SEQ_IDLE;
            s_d.done = 1'b1;
            if (!is_wr && !diag) begin
              if (s_q.req.kind == L2SEQ_K_COHRD) begin
                s_d.coh_found = 1'b1;
                s_d.primary_index_field      = tp[`L2SEQ_PRIMARY_INDEX_FIELD_MSB:`L2SEQ_PRIMARY_INDEX_FIELD_LSB];
                s_d.hit       = l2seq_match(tp, s_q.req.pa);
                s_d.hit_way   = s_q.pway;
              end else if (l2seq_match(tp, s_q.req.pa)) begin
                s_d.hit     = 1'b1;
                s_d.hit_way = s_q.pway;
                if (tp[`L2SEQ_PRIMARY_INDEX_FIELD_MSB:`L2SEQ_PRIMARY_INDEX_FIELD_LSB] !=
                    s_q.req.va[`L2SEQ_VA_IDX_MSB:`L2SEQ_VA_IDX_LSB]) begin
                  s_d.purge = 1'b1;
                  s_d.primary_index_field  = tp[`L2SEQ_PRIMARY_INDEX_FIELD_MSB:`L2SEQ_PRIMARY_INDEX_FIELD_LSB];
                end
              end else if (pred && !s_q.reissued && l2seq_match(to, s_q.req.pa)) begin
                // hit in the other way: rerun on that way, no done yet
                s_d.fsm      = L2SEQ_RUN;
                s_d.done     = 1'b0;
                s_d.cnt      = 4'h0;
                s_d.reissued = 1'b1;
                s_d.pway     = !s_q.pway;
                wpt_we       = 1'b1;
                wpt_wval     = !s_q.pway;
              end else begin
                s_d.miss = 1'b1;
              end
            end else if (s_q.req.kind == L2SEQ_K_TAGRD) begin
              s_d.tag_lo = {6'h00, tp};
            end
          end
        end
      end
      default: s_d.fsm = L2SEQ_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q        <= '0;
      s_q.tag_lo <= `L2SEQ_RST_WORD;
      s_q.tag_hi <= `L2SEQ_RST_WORD;
      s_q.ecc    <= `L2SEQ_RST_CHECK;
      s_q.fsm    <= L2SEQ_IDLE;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  // prediction memory holds no reset; entries start as way zero
  initial begin
    for (int i = 0; i < WPT_DEPTH; i++) wpt_mem[i] = 1'b0;
  end
  // plain always: the initial fill above also writes this array
  always @(posedge i_clk) begin
    if (i_ce && wpt_we) begin
      wpt_mem[wpt_widx] <= wpt_wval;
    end
  end

  assign o_req_ready = s_q.fsm == L2SEQ_IDLE && s_q.cfg_done && i_ce && !i_rst;
  assign o_awready   = !s_q.aw_ok && !s_q.bvalid;
  assign o_wready    = !s_q.w_ok && !s_q.bvalid;
  assign o_arready   = !s_q.rvalid;
  assign o_bvalid    = s_q.bvalid;
  assign o_bresp     = s_q.bresp;
  assign o_rvalid    = s_q.rvalid;
  assign o_rdata     = s_q.rdata;
  assign o_rresp     = s_q.rresp;
  assign o_sram      = s_q.sram;
  assign o_wr_take   = s_q.wr_take;
  assign o_rd_valid  = s_q.rd_valid;
  assign o_rd_data   = s_q.rd_data;
  assign o_done      = s_q.done;
  assign o_hit       = s_q.hit;
  assign o_hit_way   = s_q.hit_way;
  assign o_miss      = s_q.miss;
  assign o_purge     = s_q.purge;
  assign o_coh_found = s_q.coh_found;
  assign o_primary_index_field      = s_q.primary_index_field;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_ptag_field: assert property (o_sram.tag_oe |-> o_sram.l2_tag_bus[25:4] == s_q.req.pa[39:18])
    else $error("tag bus physical field wrong");
  chk_primary_index_field_write: assert property (o_sram.tag_oe |-> o_sram.l2_tag_bus[3:2] == s_q.req.va[13:12])
    else $error("primary index field not written");
  chk_purge_idx: assert property (o_purge |-> o_primary_index_field != s_q.req.va[13:12] && o_hit)
    else $error("purge without index mismatch");
  chk_tagway_flip: assert property (o_sram.en && o_sram.qw == 3'h1 &&
      s_q.req.kind inside {L2SEQ_K_RD8, L2SEQ_K_RD16I} |->
      o_sram.tag_way_select != o_sram.data_way_select)
    else $error("tag way not inverted on second address");
  chk_tagonly_data: assert property (o_sram.en &&
      s_q.req.kind inside {L2SEQ_K_TAGRD, L2SEQ_K_COHRD, L2SEQ_K_TAGWR} |-> !o_sram.data_en)
    else $error("tag-only sequence touched data array");
  chk_wb8_notag: assert property (o_sram.en && s_q.req.kind == L2SEQ_K_WR8 |->
      !o_sram.tag_oe && o_sram.data_way_select == s_q.req.way)
    else $error("write-back wrote tag or wrong way");
  chk_low_bit: assert property (o_sram.en && s_q.blk32 |-> !o_sram.tag_index_low_bit)
    else $error("tag index low bit driven with 32-word blocks");
  chk_diag_check: assert property (o_sram.data_we && s_q.req.kind == L2SEQ_K_WR4 |->
      o_sram.check == s_q.ecc)
    else $error("diagnostic store check field not from register");
  chk_cfg_hold: assert property (s_q.cfg_done && $past(s_q.cfg_done) |->
      $stable(s_q.blk32) && $stable(s_q.tap) && $stable(s_q.cap))
    else $error("strap settings changed after capture");
  chk_reissue_way: assert property ($rose(s_q.reissued) |->
      s_q.pway != $past(s_q.pway) && s_q.cnt == 4'h0)
    else $error("reissue did not switch way");
endmodule : l2seq_ctrl
`default_nettype wire

// file: sim/l2seq_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// external sram arrays, small index slice
// ----------------------------------------
module l2seq_sram_model
  import l2seq_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire l2seq_pkg::l2seq_sram_s i_sram,
  output logic [127:0]                o_data,
  output logic [9:0]                  o_check,
  output logic [25:0]                 o_tag
);
  logic [137:0] dmem [256];
  logic [25:0]  tmem [64];
  wire  [7:0]   da = {i_sram.data_way_select, i_sram.index[3:0], i_sram.qw};
  wire  [5:0]   ta = {i_sram.tag_way_select, i_sram.index[3:0], i_sram.tag_index_low_bit};
  initial for (int i = 0; i < 64; i++) tmem[i] = '0;
  always @(posedge i_clk) begin
    if (i_sram.en && i_sram.data_we) dmem[da] <= {i_sram.check, i_sram.data};
    if (i_sram.en && i_sram.tag_oe) tmem[ta] <= i_sram.l2_tag_bus;
  end
  // deselected arrays show inverted data so a stale sample cannot match
  assign {o_check, o_data} = i_sram.en ? dmem[da] : ~dmem[da];
  assign o_tag = i_sram.en ? tmem[ta] : ~tmem[ta];
endmodule : l2seq_sram_model
`default_nettype wire

// file: sim/l2seq_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "l2seq_defs.svh"
module l2seq_ctrl_tb;
  import l2seq_pkg::*;
  // ----------------------------------------
  // bench signals, bus and request tasks
  // ----------------------------------------
  logic i_clk = 0, i_rst = 1, i_ce = 1, i_l2_sequencing_clock = 0, i_req_valid = 0, pur;
  logic i_block_size_setting = 1, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  logic i_arvalid = 0, i_rready = 0, o_req_ready, o_wr_take, o_rd_valid, o_done, o_hit;
  logic o_hit_way, o_miss, o_purge, o_coh_found, o_awready, o_wready, o_bvalid;
  logic o_arready, o_rvalid;
  logic [2:0]   i_cache_capacity_setting = 3'h3;
  logic [1:0]   i_cache_clock_phase_tap = 2'h2, o_primary_index_field, o_bresp, o_rresp, r, pid, sv;
  logic [7:0]   i_awaddr = '0, i_araddr = '0;
  logic [31:0]  i_wdata = '0, o_rdata, d;
  logic [3:0]   i_wstrb = 4'hF;
  logic [127:0] i_wr_data = '0, i_sram_data, o_rd_data;
  logic [9:0]   i_sram_check;
  logic [25:0]  i_l2_tag_bus;
  logic [39:0]  pa;
  l2seq_req_s   i_req = '0;
  l2seq_sram_s  o_sram;
  int tests_run = 0, n_mismatch = 0, cyc = 0, n_rd, n_wt;
  l2seq_kind_e ks[4] = '{L2SEQ_K_RD16I, L2SEQ_K_RDWB, L2SEQ_K_WR8, L2SEQ_K_WRFILL};
  int ns[4] = '{4, 8, 2, 8};
  l2seq_ctrl dut (.*);
  l2seq_sram_model sram (.i_clk(i_clk), .i_sram(o_sram), .o_data(i_sram_data),
                         .o_check(i_sram_check), .o_tag(i_l2_tag_bus));
  always #20 i_clk = ~i_clk;
  // cache clock free-running at one eighth of i_clk, its edges on i_clk falling edges
  always #160 i_l2_sequencing_clock = ~i_l2_sequencing_clock;
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_wr_take) i_wr_data <= i_wr_data + 128'h1;
    if (o_sram.tag_index_low_bit === 1'b1) chk(1, 0);
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    {i_awaddr, i_wdata} <= {a, v};
    {i_awvalid, i_wvalid, i_bready} <= 3'h7;
    while (!o_bvalid) begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end
    i_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_araddr <= a;
    {i_arvalid, i_rready} <= 2'h3;
    while (!o_rvalid) begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 1'b0;
    end
    {d, r} = {o_rdata, o_rresp};
    i_rready <= 1'b0;
  endtask : rd
  task automatic req(input l2seq_kind_e k, input logic [39:0] a, input logic [13:0] v,
                     input logic w, input l2seq_blk_e s);
    int n;
    n = 0;
    {n_rd, n_wt, pur} = '0;
    @(posedge i_clk);
    i_req <= '{k, a, v, w, s};
    i_req_valid <= 1'b1;
    do @(posedge i_clk); while (!o_req_ready);
    i_req_valid <= 1'b0;
    while (!o_done && n < 400) begin
      @(posedge i_clk);
      n++;
      n_rd += o_rd_valid;
      n_wt += o_wr_take;
      if (o_purge || o_coh_found) {pur, pid} = {1'b1, o_primary_index_field};
    end
    if (!o_done) chk(0, 1);
  endtask : req
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clk);
    wr(`L2SEQ_REG_TAG_LO, 32'h1234_5678);
    wr(`L2SEQ_REG_TAG_HI, 32'h9ABC_DEF0);
    wr(`L2SEQ_REG_CHECK, 32'hFFFF_F2A5);
    rd(`L2SEQ_REG_CONFIG);
    chk(d, 32'h0000_0027);
    rd(8'h40);
    chk(r, `L2SEQ_RESP_SLV);
    $display("test regs done");
    req(L2SEQ_K_WR4, 40'h140, 14'h9, 1'b0, L2SEQ_ST_INVALID);
    wr(`L2SEQ_REG_CHECK, '0);
    req(L2SEQ_K_RD4, 40'h140, 14'h1, 1'b0, L2SEQ_ST_INVALID);
    rd(`L2SEQ_REG_TAG_HI);
    chk(d, '0);
    rd(`L2SEQ_REG_CHECK);
    chk(d, 32'h0000_02A5);
    req(L2SEQ_K_RD4, 40'h140, 14'h9, 1'b0, L2SEQ_ST_INVALID);
    rd(`L2SEQ_REG_TAG_HI);
    chk(d, 32'h9ABC_DEF0);
    rd(`L2SEQ_REG_TAG_LO);
    chk(d, 32'h1234_5678);
    $display("test diag data done");
    for (int s = 0; s < 4; s++) begin
      sv = 2'(s);
      pa = {22'h3C5A1 ^ 22'(s), 18'h00080};
      req(L2SEQ_K_TAGWR, pa, {~sv, 12'h0}, sv[0], l2seq_blk_e'(sv));
      req(L2SEQ_K_TAGRD, pa, {13'h0, sv[0]}, 1'b0, L2SEQ_ST_INVALID);
      rd(`L2SEQ_REG_TAG_LO);
      chk(d, {6'h0, pa[39:18], ~sv, sv});
    end
    $display("test tag done");
    req(L2SEQ_K_RD8, pa, '0, 1'b0, L2SEQ_ST_INVALID);
    rd(`L2SEQ_REG_STATUS);
    chk(d, 32'h0000_0016);
    req(L2SEQ_K_RD8, pa, 14'h1000, 1'b0, L2SEQ_ST_INVALID);
    chk(n_rd, 2);
    chk({pur, pid}, 3'h4);
    rd(`L2SEQ_REG_STATUS);
    chk(d, 32'h0000_0006);
    req(L2SEQ_K_COHRD, pa, '0, 1'b0, L2SEQ_ST_INVALID);
    chk({pur, pid, o_hit}, 4'hA);
    req(L2SEQ_K_RD8, 40'h00_0000_0080, '0, 1'b0, L2SEQ_ST_INVALID);
    rd(`L2SEQ_REG_STATUS);
    chk(d, 32'h0000_0008);
    $display("test prediction done");
    foreach (ks[i]) begin
      req(ks[i], pa, '0, 1'b1, L2SEQ_ST_DIRTY);
      chk(n_rd + n_wt, ns[i]);
    end
    $display("test block lengths done");
    final_report();
  end
endmodule : l2seq_ctrl_tb
`default_nettype wire
